/* ptp_time_pkg.sv */
// package: constants and carrier types for the precision-time system time and frame match block
// assumes a single 100 MHz core clock and no software-visible register map
// Function
// R1: hold 64-bit system time for snapshots
// R2: initialize loads whole time from update value
// R3: coarse correction adds or subtracts update value
// R4: fine mode adds addend every cycle
// R5: accumulator carry increments time, else hold
// R6: accumulator and addend are 32 bits
// R7: each carry advances time by 20 ns
// R8: software programs initial addend value
// R9: software rewrites addend after each sync
// R10: separate match criteria per transport; the classifier implements only the ipv4 criteria
// R11: vlan tag shifts octet positions by 4
// R12: ipv4 ethertype, version, udp protocol checked
// R13: ipv4 destination must be ptp multicast group
// R14: udp port 0x013f event, 0x0140 general
// R15: decode v1 control and v2 message type
// R16: sync, delay req, v2 pdelay are events
// R17: type and version nibbles share header octets
// R18: digital or binary nanosecond rollover select
// R19: time is seconds word over nanoseconds word
// R20: self-clearing request bits read busy
// R21: failed match flags no snapshot
package ptp_time_pkg;

   // time step per carry, 50 MHz effective rate
   localparam int unsigned STEP_NS = 20;
   localparam logic [31:0] NS_STEP = 32'h0000_0014;
   localparam logic [31:0] NS_MAX_DIGITAL = 32'h3B9A_C9FF;
   localparam logic [31:0] NS_MAX_BINARY = 32'h7FFF_FFFF;
   localparam logic [63:0] TIME_RESET = 64'h0000_0000_0000_0000;
   localparam logic [31:0] ADDEND_RESET = 32'h0000_0000;

   // frame octet positions, untagged
   localparam int unsigned VLAN_SHIFT = 4;
   localparam int unsigned OCT_ETYPE_HI = 12;
   localparam int unsigned OCT_ETYPE_LO = 13;
   localparam int unsigned OCT_IP_VER = 14;
   localparam int unsigned OCT_IP_PROTO = 23;
   localparam int unsigned OCT_IP_DA0 = 30;
   localparam int unsigned OCT_IP_DA1 = 31;
   localparam int unsigned OCT_IP_DA2 = 32;
   localparam int unsigned OCT_IP_DA3 = 33;
   localparam int unsigned OCT_UDP_PORT_HI = 36;
   localparam int unsigned OCT_UDP_PORT_LO = 37;
   localparam int unsigned OCT_V2_TYPE = 42;
   localparam int unsigned OCT_V2_VER = 43;
   localparam int unsigned OCT_V1_CTRL = 74;
   localparam int unsigned OCT_LAST = 78;

   // match values
   localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
   localparam logic [15:0] ETYPE_VLAN = 16'h8100;
   localparam logic [7:0] IPV4_VER_IHL = 8'h45;
   localparam logic [7:0] PROTO_UDP = 8'h11;
   localparam logic [7:0] MC_OCT0 = 8'hE0;
   localparam logic [7:0] MC_OCT1 = 8'h00;
   localparam logic [7:0] MC_PRI_OCT2 = 8'h01;
   localparam logic [7:0] MC_PRI_LO = 8'h81;
   localparam logic [7:0] MC_PRI_HI = 8'h84;
   localparam logic [7:0] MC_PD_OCT2 = 8'h00;
   localparam logic [7:0] MC_PD_OCT3 = 8'h6B;
   localparam logic [15:0] PORT_EVENT = 16'h013F;
   localparam logic [15:0] PORT_GENERAL = 16'h0140;
   localparam logic [3:0] VER_1 = 4'h1;
   localparam logic [3:0] VER_2 = 4'h2;

   // message codes
   localparam logic [7:0] V1_SYNC = 8'h00;
   localparam logic [7:0] V1_DELAY_REQ = 8'h01;
   localparam logic [7:0] V1_MGMT = 8'h04;
   localparam logic [3:0] V2_SYNC = 4'h0;
   localparam logic [3:0] V2_DELAY_REQ = 4'h1;
   localparam logic [3:0] V2_PDELAY_REQ = 4'h2;
   localparam logic [3:0] V2_PDELAY_RESP = 4'h3;
   localparam logic [3:0] V2_GEN_LO = 4'h8;
   localparam logic [3:0] V2_GEN_HI = 4'hD;

   typedef enum logic [1:0] {
      TRANSPORT_NONE,
      TRANSPORT_IPV4,
      TRANSPORT_IPV6,
      TRANSPORT_ETHER
   } transport_e;

   // software command group
   typedef struct packed {
      logic        init_req;
      logic        corr_req;
      logic        corr_sub;
      logic        fine_mode;
      logic        rollover_style_select;
      logic [31:0] addend;
      logic [31:0] upd_sec;
      logic [31:0] upd_ns;
   } time_ctrl_s;

   // system time word
   typedef struct packed {
      logic [31:0] sec;
      logic [31:0] ns;
   } sys_time_s;

   // frame byte stream from the mac path
   typedef struct packed {
      logic       valid;
      logic       sof;
      logic       eof;
      logic [7:0] data;
   } frame_byte_s;

   // classification result
   typedef struct packed {
      logic       done;
      logic       is_ptp;
      logic       is_event;
      logic       snapshot;
      logic       version2;
      transport_e transport;
      logic [3:0] msg_type;
   } frame_class_s;

endpackage

/* ptp_frame_match.sv */
// frame classifier: matches ptp over udp/ipv4 header fields in a byte stream
// assumes one byte per valid cycle from the mac path on core_clk
`timescale 1ns/10ps
module ptp_frame_match (
   // clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst_b,
   // frame bytes
   input  wire ptp_time_pkg::frame_byte_s   frame_in,
   // result, one-cycle done at eof
   output ptp_time_pkg::frame_class_s       class_out
);
   import ptp_time_pkg::*;

   logic [6:0]   idx_ff, nxt_idx;
   logic         vlan_ff, nxt_vlan;
   logic         ok_ff, nxt_ok;          // all fixed fields matched so far
   logic         ev_port_ff, nxt_ev_port;
   logic [7:0]   v2b_ff, nxt_v2b;
   logic [7:0]   v2v_ff, nxt_v2v;
   logic [7:0]   v1c_ff, nxt_v1c;
   logic [7:0]   da2_ff, nxt_da2;
   logic [7:0]   prev_ff, nxt_prev;
   frame_class_s res_ff, nxt_res;
   logic [6:0]   pos;
   logic [6:0]   shift;
   logic         ev;
   logic         v2;

   // position relative to untagged layout
   always_comb begin
      shift = vlan_ff ? 7'(VLAN_SHIFT) : 7'd0; // see R11
      pos   = idx_ff - shift;
   end

   // field checks per byte, only the ipv4 table is implemented here
   always_comb begin
      nxt_idx     = idx_ff;
      nxt_vlan    = vlan_ff;
      nxt_ok      = ok_ff;
      nxt_ev_port = ev_port_ff;
      nxt_v2b     = v2b_ff;
      nxt_v2v     = v2v_ff;
      nxt_v1c     = v1c_ff;
      nxt_da2     = da2_ff;
      nxt_prev    = prev_ff;
      nxt_res     = '0;
      ev          = 1'b0;
      v2          = 1'b0;
      if (frame_in.valid) begin
         if (frame_in.sof) begin
            nxt_idx  = 7'd1;
            nxt_vlan = 1'b0;
            nxt_ok   = 1'b1;
         end else if (idx_ff != 7'h7F) begin
            nxt_idx = idx_ff + 7'd1;
         end
         nxt_prev = frame_in.data;
         if (!frame_in.sof) begin
            // tag detection at untagged ethertype slot
            if (idx_ff == 7'(OCT_ETYPE_LO) && !vlan_ff && {prev_ff, frame_in.data} == ETYPE_VLAN)
               nxt_vlan = 1'b1; // see R11
            else if (pos == 7'(OCT_ETYPE_LO) && {prev_ff, frame_in.data} != ETYPE_IPV4)
               nxt_ok = 1'b0; // see R12
            if (pos == 7'(OCT_IP_VER) && frame_in.data != IPV4_VER_IHL)
               nxt_ok = 1'b0; // see R12
            if (pos == 7'(OCT_IP_PROTO) && frame_in.data != PROTO_UDP)
               nxt_ok = 1'b0; // see R12
            if (pos == 7'(OCT_IP_DA0) && frame_in.data != MC_OCT0)
               nxt_ok = 1'b0; // see R13
            if (pos == 7'(OCT_IP_DA1) && frame_in.data != MC_OCT1)
               nxt_ok = 1'b0; // see R13
            if (pos == 7'(OCT_IP_DA2))
               nxt_da2 = frame_in.data;
            if (pos == 7'(OCT_IP_DA3) &&
                !((da2_ff == MC_PRI_OCT2 && frame_in.data >= MC_PRI_LO && frame_in.data <= MC_PRI_HI) ||
                  (da2_ff == MC_PD_OCT2 && frame_in.data == MC_PD_OCT3)))
               nxt_ok = 1'b0; // see R13
            if (pos == 7'(OCT_UDP_PORT_LO)) begin
               nxt_ev_port = ({prev_ff, frame_in.data} == PORT_EVENT); // see R14
               if ({prev_ff, frame_in.data} != PORT_EVENT && {prev_ff, frame_in.data} != PORT_GENERAL)
                  nxt_ok = 1'b0; // see R14
            end
            if (pos == 7'(OCT_V2_TYPE))
               nxt_v2b = frame_in.data; // see R17
            if (pos == 7'(OCT_V2_VER))
               nxt_v2v = frame_in.data; // see R17
            if (pos == 7'(OCT_V1_CTRL))
               nxt_v1c = frame_in.data; // see R15
         end
         if (frame_in.eof) begin
            // short frames never reach the last octet and fail
            v2 = (v2v_ff[3:0] == VER_2); // see R17
            if (v2)
               ev = (v2b_ff[3:0] == V2_SYNC) || (v2b_ff[3:0] == V2_DELAY_REQ) ||
                    (v2b_ff[3:0] == V2_PDELAY_REQ) || (v2b_ff[3:0] == V2_PDELAY_RESP); // see R16
            else
               ev = (v1c_ff == V1_SYNC) || (v1c_ff == V1_DELAY_REQ); // see R16
            nxt_res.done      = 1'b1;
            nxt_res.version2  = v2;
            nxt_res.msg_type  = v2 ? v2b_ff[3:0] : v1c_ff[3:0];
            nxt_res.is_ptp    = ok_ff && pos >= 7'(OCT_LAST) &&
                                (v2 ? ((v2b_ff[3:0] <= V2_PDELAY_RESP) ||
                                       (v2b_ff[3:0] >= V2_GEN_LO && v2b_ff[3:0] <= V2_GEN_HI))
                                    : (v2v_ff[3:0] == VER_1 && v1c_ff <= V1_MGMT)); // see R15
            nxt_res.is_event  = nxt_res.is_ptp && ev && ev_port_ff;
            nxt_res.snapshot  = nxt_res.is_event; // see R21
            nxt_res.transport = nxt_res.is_ptp ? TRANSPORT_IPV4 : TRANSPORT_NONE; // see R10
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         idx_ff     <= 7'd0;
         vlan_ff    <= 1'b0;
         ok_ff      <= 1'b0;
         ev_port_ff <= 1'b0;
         v2b_ff     <= 8'h00;
         v2v_ff     <= 8'h00;
         v1c_ff     <= 8'h00;
         da2_ff     <= 8'h00;
         prev_ff    <= 8'h00;
         res_ff     <= '0;
      end else begin
         idx_ff     <= nxt_idx;
         vlan_ff    <= nxt_vlan;
         ok_ff      <= nxt_ok;
         ev_port_ff <= nxt_ev_port;
         v2b_ff     <= nxt_v2b;
         v2v_ff     <= nxt_v2v;
         v1c_ff     <= nxt_v1c;
         da2_ff     <= nxt_da2;
         prev_ff    <= nxt_prev;
         res_ff     <= nxt_res;
      end
   end

   assign class_out = res_ff;

   // a failed match can never raise the snapshot flag
   property p_no_snap_without_ptp;
      @(posedge core_clk) disable iff (!rst_b) class_out.snapshot |-> class_out.is_ptp && class_out.done;
   endproperty
   a_no_snap_without_ptp: assert property (p_no_snap_without_ptp) else $error("snapshot without match"); // see R21

   // result appears one cycle after the last byte
   property p_done_after_eof;
      @(posedge core_clk) disable iff (!rst_b) frame_in.valid && frame_in.eof |=> class_out.done;
   endproperty
   a_done_after_eof: assert property (p_done_after_eof) else $error("no result after eof"); // see R10

   // general port never yields an event
   property p_general_not_event;
      @(posedge core_clk) disable iff (!rst_b)
         frame_in.valid && frame_in.eof && !ev_port_ff |=> !class_out.is_event;
   endproperty
   a_general_not_event: assert property (p_general_not_event) else $error("event on general port"); // see R14

   // wrong protocol octet kills the frame
   property p_proto_mismatch;
      @(posedge core_clk) disable iff (!rst_b)
         frame_in.valid && !frame_in.sof && pos == 7'(OCT_IP_PROTO) && frame_in.data != PROTO_UDP |=> !ok_ff;
   endproperty
   a_proto_mismatch: assert property (p_proto_mismatch) else $error("udp mismatch not caught"); // see R12

endmodule

/* ptp_system_time.sv */
// system time counter with coarse and fine correction plus frame classifier
// assumes command levels from logic on core_clk, which stands in for the time reference clock
`timescale 1ns/10ps
module ptp_system_time (
   // clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst_b,
   // software control
   input  wire ptp_time_pkg::time_ctrl_s    ctrl_in,
   output logic                             init_busy,
   output logic                             corr_busy,
   // time out
   output ptp_time_pkg::sys_time_s          sys_time,
   output logic                             time_tick,
   // frame path
   input  wire ptp_time_pkg::frame_byte_s   frame_in,
   output ptp_time_pkg::frame_class_s       class_out,
   output ptp_time_pkg::sys_time_s          snap_time,
   output logic                             snap_valid
);
   import ptp_time_pkg::*;

   logic [31:0] acc_ff, nxt_acc;
   logic [31:0] sec_ff, nxt_sec;
   logic [31:0] ns_ff, nxt_ns;
   logic        init_pend_ff, nxt_init_pend;
   logic        corr_pend_ff, nxt_corr_pend;
   logic        init_req_d_ff, corr_req_d_ff;
   logic        tick_ff, nxt_tick;
   logic [32:0] acc_sum;
   logic        carry;
   logic [31:0] ns_max;
   logic [32:0] ns_add;
   logic [32:0] ns_sub;
   sys_time_s   snap_ff, nxt_snap;
   logic        snap_v_ff, nxt_snap_v;
   frame_class_s cls;

   ptp_frame_match u_match (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .frame_in  (frame_in),
      .class_out (cls)
   );

   // accumulator: 32-bit addend summed every cycle in fine mode, carry from bit 32
   always_comb begin
      acc_sum = {1'b0, acc_ff} + {1'b0, ctrl_in.addend}; // see R4 see R6
      // without fine mode every cycle counts as a step
      carry   = ctrl_in.fine_mode ? acc_sum[32] : 1'b1; // see R5
      nxt_acc = ctrl_in.fine_mode ? acc_sum[31:0] : acc_ff;
   end

   // request bits rise once, pending flag stays set until applied
   always_comb begin
      nxt_init_pend = init_pend_ff | (ctrl_in.init_req & ~init_req_d_ff); // see R20
      nxt_corr_pend = corr_pend_ff | (ctrl_in.corr_req & ~corr_req_d_ff); // see R20
      ns_max = ctrl_in.rollover_style_select ? NS_MAX_DIGITAL : NS_MAX_BINARY; // see R18
      ns_add = {1'b0, ns_ff} + {1'b0, ctrl_in.upd_ns};
      ns_sub = {1'b0, ns_ff} - {1'b0, ctrl_in.upd_ns};
      nxt_sec  = sec_ff;
      nxt_ns   = ns_ff;
      nxt_tick = 1'b0;
      if (init_pend_ff) begin
         nxt_sec       = ctrl_in.upd_sec; // see R2
         nxt_ns        = ctrl_in.upd_ns;
         nxt_init_pend = 1'b0;
      end else if (corr_pend_ff) begin
         // one-step offset; sec borrow/carry on ns wrap
         if (ctrl_in.corr_sub) begin
            if (ns_sub[32]) begin
               nxt_ns  = ns_sub[31:0] + ns_max + 32'd1; // see R3
               nxt_sec = sec_ff - ctrl_in.upd_sec - 32'd1;
            end else begin
               nxt_ns  = ns_sub[31:0];
               nxt_sec = sec_ff - ctrl_in.upd_sec;
            end
         end else if (ns_add > {1'b0, ns_max}) begin
            nxt_ns  = 32'(ns_add - {1'b0, ns_max} - 33'd1); // see R3
            nxt_sec = sec_ff + ctrl_in.upd_sec + 32'd1;
         end else begin
            nxt_ns  = ns_add[31:0];
            nxt_sec = sec_ff + ctrl_in.upd_sec;
         end
         nxt_corr_pend = 1'b0;
      end else if (carry) begin
         nxt_tick = 1'b1;
         if ({1'b0, ns_ff} + {1'b0, NS_STEP} > {1'b0, ns_max}) begin
            nxt_ns  = 32'({1'b0, ns_ff} + {1'b0, NS_STEP} - {1'b0, ns_max} - 33'd1); // see R18
            nxt_sec = sec_ff + 32'd1;
         end else begin
            nxt_ns = ns_ff + NS_STEP; // see R7
         end
      end
      // request edges arriving while applied stay pending
      if (init_pend_ff && ctrl_in.init_req && !init_req_d_ff)
         nxt_init_pend = 1'b1;
      if (corr_pend_ff && !init_pend_ff && ctrl_in.corr_req && !corr_req_d_ff)
         nxt_corr_pend = 1'b1;
   end

   // snapshot on event frames only
   always_comb begin
      nxt_snap   = snap_ff;
      nxt_snap_v = 1'b0;
      if (cls.done && cls.snapshot) begin
         nxt_snap   = '{sec: sec_ff, ns: ns_ff}; // see R1 see R21
         nxt_snap_v = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         acc_ff        <= ADDEND_RESET;
         sec_ff        <= TIME_RESET[63:32];
         ns_ff         <= TIME_RESET[31:0];
         init_pend_ff  <= 1'b0;
         corr_pend_ff  <= 1'b0;
         init_req_d_ff <= 1'b0;
         corr_req_d_ff <= 1'b0;
         tick_ff       <= 1'b0;
         snap_ff       <= '0;
         snap_v_ff     <= 1'b0;
      end else begin
         acc_ff        <= nxt_acc;
         sec_ff        <= nxt_sec;
         ns_ff         <= nxt_ns;
         init_pend_ff  <= nxt_init_pend;
         corr_pend_ff  <= nxt_corr_pend;
         init_req_d_ff <= ctrl_in.init_req;
         corr_req_d_ff <= ctrl_in.corr_req;
         tick_ff       <= nxt_tick;
         snap_ff       <= nxt_snap;
         snap_v_ff     <= nxt_snap_v;
      end
   end

   // outputs; busy reads one until the operation lands
   assign sys_time   = '{sec: sec_ff, ns: ns_ff}; // see R19
   assign time_tick  = tick_ff;
   assign init_busy  = init_pend_ff; // see R20
   assign corr_busy  = corr_pend_ff;
   assign class_out  = cls;
   assign snap_time  = snap_ff;
   assign snap_valid = snap_v_ff;

   sequence s_init_edge;
      ctrl_in.init_req && !init_req_d_ff && !init_pend_ff;
   endsequence

   sequence s_init_land;
      init_busy ##1 (!init_busy && sys_time.sec == $past(ctrl_in.upd_sec) && sys_time.ns == $past(ctrl_in.upd_ns));
   endsequence

   property p_init_loads;
      @(posedge core_clk) disable iff (!rst_b) s_init_edge |=> s_init_land;
   endproperty
   a_init_loads: assert property (p_init_loads) else $error("init did not load update value"); // see R2

   property p_hold_without_carry;
      @(posedge core_clk) disable iff (!rst_b)
         ctrl_in.fine_mode && !acc_sum[32] && !init_pend_ff && !corr_pend_ff |=> $stable(sys_time);
   endproperty
   a_hold_without_carry: assert property (p_hold_without_carry) else $error("time moved without carry"); // see R5

   property p_step_20ns;
      @(posedge core_clk) disable iff (!rst_b)
         carry && !init_pend_ff && !corr_pend_ff && ns_ff < 32'h3B9A_C9E0 |=> sys_time.ns == $past(ns_ff) + 32'd20;
   endproperty
   a_step_20ns: assert property (p_step_20ns) else $error("step is not 20 ns"); // see R7

   property p_acc_adds;
      @(posedge core_clk) disable iff (!rst_b)
         ctrl_in.fine_mode |=> acc_ff == $past(acc_ff) + $past(ctrl_in.addend);
   endproperty
   a_acc_adds: assert property (p_acc_adds) else $error("accumulator did not add addend"); // see R4

   property p_digital_wrap;
      @(posedge core_clk) disable iff (!rst_b)
         ctrl_in.rollover_style_select |-> ns_ff <= NS_MAX_DIGITAL || !$past(ctrl_in.rollover_style_select) ||
                                           $past(init_pend_ff);
   endproperty
   a_digital_wrap: assert property (p_digital_wrap) else $error("ns beyond digital limit"); // see R18

   property p_corr_add;
      @(posedge core_clk) disable iff (!rst_b)
         corr_pend_ff && !init_pend_ff && !ctrl_in.corr_sub && ns_add <= {1'b0, ns_max}
         |=> sys_time.sec == $past(sec_ff) + $past(ctrl_in.upd_sec);
   endproperty
   a_corr_add: assert property (p_corr_add) else $error("coarse add wrong"); // see R3

   property p_snap_event;
      @(posedge core_clk) disable iff (!rst_b)
         cls.done && cls.snapshot |=> snap_valid && snap_time == $past(sys_time);
   endproperty
   a_snap_event: assert property (p_snap_event) else $error("snapshot not captured"); // see R1

   property p_corr_busy_clears;
      @(posedge core_clk) disable iff (!rst_b) corr_busy && !init_busy |=> ##[0:1] !corr_busy;
   endproperty
   a_corr_busy_clears: assert property (p_corr_busy_clears) else $error("correction stuck busy"); // see R20

endmodule

/* mac_frame_path.sv */
// partner model: mac frame path handing frame bytes to the classifier
// assumes the bench fills byte_q and calls send_frame from its own thread
`timescale 1ns/10ps
module mac_frame_path (
   // clock
   input  wire logic                 core_clk,
   // frame bytes toward the classifier
   output ptp_time_pkg::frame_byte_s frame_out
);
   import ptp_time_pkg::*;
   logic [7:0] byte_q[$];

   initial frame_out = '0;

   // one byte per valid cycle; slow mode inserts idle gaps
   // idle data is inverted so a stale byte is never mistaken for a held one
   task automatic send_frame(input bit slow);
      int n;
      n = byte_q.size();
      for (int i = 0; i < n; i++) begin
         while (slow && $urandom_range(2) == 0) begin
            @(posedge core_clk);
            frame_out <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~byte_q[i]};
         end
         @(posedge core_clk);
         frame_out <= '{valid: 1'b1, sof: i == 0, eof: i == n - 1, data: byte_q[i]};
      end
      @(posedge core_clk);
      frame_out <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~byte_q[n - 1]};
   endtask
endmodule

/* ptp_system_time_and_frame_match_test.sv */
// testbench: drives time controls and frames, checks against a behavioural model
// assumes ptp_system_time, mac_frame_path and the package are compiled first
`timescale 1ns/10ps
module ptp_system_time_and_frame_match_test;
   import ptp_time_pkg::*;
   logic         core_clk = 1'b0;
   logic         rst_b = 1'b0;
   time_ctrl_s   ctrl = '0;
   frame_byte_s  frame_in;
   logic         init_busy, corr_busy, time_tick, snap_valid;
   sys_time_s    sys_time, snap_time;
   frame_class_s class_out;
   int           miscompares = 0;
   int           n_compared = 0;
   longint       m_sec, m_ns;

   always #5 core_clk = ~core_clk;

   ptp_system_time uut (.core_clk(core_clk), .rst_b(rst_b), .ctrl_in(ctrl), .init_busy(init_busy),
      .corr_busy(corr_busy), .sys_time(sys_time), .time_tick(time_tick), .frame_in(frame_in),
      .class_out(class_out), .snap_time(snap_time), .snap_valid(snap_valid));
   mac_frame_path mac (.core_clk(core_clk), .frame_out(frame_in));

   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk_time(input logic [63:0] got, input longint s, input longint n, input string what);
      n_compared++;
      if (got !== {s[31:0], n[31:0]}) begin
         miscompares++;
         $display("Error %0t: %s time %h", $time, what, got);
      end
   endtask

   task automatic chk_flag(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // nanosecond wrap point of the selected rollover style
   function automatic longint lim();
      return ctrl.rollover_style_select ? 64'd1_000_000_000 : 64'h8000_0000;
   endfunction

   // model of a coarse add or subtract, with carry and borrow across the words
   function automatic void apply(input bit sub, input longint us, input longint un);
      m_sec = sub ? m_sec - us : m_sec + us;
      m_ns = sub ? m_ns - un : m_ns + un;
      if (m_ns < 0) begin
         m_ns += lim();
         m_sec--;
      end
      if (m_ns >= lim()) begin
         m_ns -= lim();
         m_sec++;
      end
   endfunction

   // one coarse request: level edge, busy for one cycle, then the new time
   task automatic coarse(input bit ini, input bit sub, input longint s, input longint n);
      int k;
      @(posedge core_clk);
      ctrl.upd_sec <= s[31:0];
      ctrl.upd_ns <= n[31:0];
      ctrl.corr_sub <= sub;
      if (ini) ctrl.init_req <= 1'b1;
      else ctrl.corr_req <= 1'b1;
      k = 0;
      do @(negedge core_clk); while ((ini ? init_busy : corr_busy) !== 1'b1 && ++k < 6);
      chk_flag(ini ? init_busy : corr_busy, 8'h01, "busy");
      @(posedge core_clk);
      ctrl.init_req <= 1'b0;
      ctrl.corr_req <= 1'b0;
      if (ini) begin
         m_sec = s;
         m_ns = n;
      end
      else apply(sub, s, n);
      @(negedge core_clk);
      chk_flag(ini ? init_busy : corr_busy, 8'h00, "busy clear");
      chk_time(sys_time, m_sec, m_ns, "coarse");
   endtask

   // udp/ipv4 frame, optionally tagged, with at most one broken field
   task automatic build(input int i, output bit ptp, output bit ev, output bit v2, output logic [3:0] mt);
      int o, f, g;
      bit evp;
      logic [7:0] ctl;
      o = $urandom_range(1) * VLAN_SHIFT;
      f = i < 15 ? 0 : $urandom_range(9);
      g = $urandom_range(4);
      v2 = i < 10 ? 1'b1 : i < 15 ? 1'b0 : 1'($urandom_range(1));
      mt = 4'(i < 10 ? i : $urandom_range(9));
      if (mt > 3) mt += 4'h4;
      ctl = 8'(i >= 10 && i < 15 ? i - 10 : $urandom_range(4));
      evp = i < 15 || $urandom_range(1);
      mac.byte_q.delete();
      repeat (OCT_LAST + 1 + o) mac.byte_q.push_back(8'($urandom()));
      if (o != 0) {mac.byte_q[12], mac.byte_q[13]} = ETYPE_VLAN;
      {mac.byte_q[12 + o], mac.byte_q[13 + o]} = f == 1 ? 16'h0801 : ETYPE_IPV4;
      mac.byte_q[14 + o] = f == 2 ? 8'h46 : IPV4_VER_IHL;
      mac.byte_q[23 + o] = f == 3 ? 8'h06 : PROTO_UDP;
      {mac.byte_q[30 + o], mac.byte_q[31 + o], mac.byte_q[32 + o], mac.byte_q[33 + o]} =
         g < 4 ? {MC_OCT0, MC_OCT1, MC_PRI_OCT2, 8'(MC_PRI_LO + g)} : {MC_OCT0, MC_OCT1, MC_PD_OCT2, MC_PD_OCT3};
      if (f == 4) mac.byte_q[32 + o] = 8'h02;
      {mac.byte_q[36 + o], mac.byte_q[37 + o]} = evp ? PORT_EVENT : PORT_GENERAL;
      if (f == 5) mac.byte_q[37 + o] = 8'h41;
      mac.byte_q[42 + o] = {4'($urandom()), mt};
      mac.byte_q[43 + o] = {4'($urandom()), v2 ? VER_2 : VER_1};
      mac.byte_q[74 + o] = ctl;
      if (f == 6) void'(mac.byte_q.pop_back());
      ptp = f == 0 || f > 6;
      ev = ptp && evp && (v2 ? mt <= 3 : ctl <= 1);
   endtask

   initial begin
      int c, tk;
      longint t0, t1, ex, ad;
      logic [3:0] mt;
      bit ptp, ev, v2;
      // watchdog: the whole run needs well under 10,000 cycles
      fork
         begin
            #300_000;
            miscompares++;
            give_verdict();
         end
      join_none
      void'($urandom(32'hed652e21));
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      ctrl.fine_mode <= 1'b1;
      ctrl.rollover_style_select <= 1'b1;
      @(negedge core_clk);
      chk_time(sys_time, 0, 0, "reset");
      // addend zero: time must hold, so coarse results are exact
      coarse(1, 0, 5, 999_999_990);
      coarse(0, 0, 0, 20);
      coarse(0, 1, 1, 30);
      for (int i = 0; i < 5; i++)
         coarse(i < 2, i >= 2 && $urandom_range(1), i < 2 ? $urandom_range(2000, 1000) : $urandom_range(400),
            $urandom_range(999_999_999));
      // free-running steps across both wrap points
      for (int m = 0; m < 2; m++) begin
         @(posedge core_clk);
         ctrl.rollover_style_select <= m[0];
         ctrl.fine_mode <= 1'b0;
         coarse(1, 0, 7, m == 1 ? 999_999_990 : 32'h7FFF_FFF0);
         apply(0, 0, STEP_NS);
         @(negedge core_clk);
         chk_time(sys_time, m_sec, m_ns, "rollover");
      end
      @(posedge core_clk);
      ctrl.fine_mode <= 1'b1;
      ctrl.rollover_style_select <= 1'b1;
      coarse(1, 0, 0, 0);
      // fine mode: 2^32 over a ratio of 2 first, then rewritten addends
      for (int j = 0; j < 4; j++) begin
         ad = j == 0 ? 64'h8000_0000 : 64'($urandom());
         @(posedge core_clk);
         ctrl.addend <= ad[31:0];
         repeat (2) @(negedge core_clk);
         t0 = sys_time.ns;
         tk = 0;
         repeat (64) begin
            @(negedge core_clk);
            tk += time_tick;
         end
         t1 = sys_time.ns;
         c = int'((t1 - t0) / STEP_NS);
         ex = (64 * ad) >> 32;
         chk_flag(8'((t1 - t0) % STEP_NS), 8'h00, "step size");
         chk_flag(8'(c >= ex && c <= ex + 1), 8'h01, "carry count");
         chk_flag(8'(tk >= c - 1 && tk <= c + 1), 8'h01, "ticks");
      end
      @(posedge core_clk);
      ctrl.addend <= '0;
      // frames: every code once, then random faults; random tags throughout, random idle gaps on odd-numbered frames
      for (int i = 0; i < 40; i++) begin
         build(i, ptp, ev, v2, mt);
         mac.send_frame(i[0]);
         c = 0;
         do @(negedge core_clk); while (class_out.done !== 1'b1 && ++c < 5);
         chk_flag(class_out.done, 8'h01, "done");
         chk_flag(class_out.is_ptp, ptp, "ptp");
         chk_flag(class_out.is_event, ev, "event");
         chk_flag(class_out.snapshot, ev, "snapshot");
         if (ptp) chk_flag({class_out.version2, class_out.transport}, {v2, TRANSPORT_IPV4}, "kind");
         if (ptp && v2) chk_flag(class_out.msg_type, mt, "type");
         @(negedge core_clk);
         chk_flag(snap_valid, ev, "snap");
         if (ev) chk_time(snap_time, sys_time.sec, sys_time.ns, "snap time");
      end
      give_verdict();
   end
endmodule
